// [rtl/dich_mon_map.sv]
`timescale 1ns/100ps
`default_nettype none
module dich_mon_map (
  input wire logic [7:0] code,
  input wire logic upper,
  input wire dich_pkg::dich_mon_src_t src,
  output logic [15:0] value
);

  // Sources are raw frequency, current and voltage values, never scaled by the speed display settings
  always_comb begin
    case (code)
      dich_pkg::MC_FREQ0: value = upper ? dich_pkg::sat16(src.out_freq) : 16'h0000;
      dich_pkg::MC_FREQ1: value = dich_pkg::sat16(src.out_freq);
      dich_pkg::MC_CURRENT: value = dich_pkg::sat16(src.out_current);
      dich_pkg::MC_VOLTAGE: value = dich_pkg::sat16(src.out_voltage);
      dich_pkg::MC_SET_FREQ: value = dich_pkg::sat16(src.set_freq);
      default: value = 16'h0000;
    endcase
  end

endmodule
`default_nettype wire

// [rtl/dich_pkg.sv]
package dich_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_MSEL_FIRST = 8'h10;
  localparam logic [7:0] OFS_MSEL_THIRD = 8'h14;
  localparam logic [7:0] OFS_MRES_FIRST = 8'h24;
  localparam int NUM_MSEL_MORE = 4;
  localparam int NUM_MRES = 6;

  // Field positions
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_DATA_LSB = 16;
  localparam int CTRL_RAM_ONLY_BIT = 0;
  localparam int CTRL_LINK_EXT_LSB = 8;
  localparam int STAT_OK_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_RD_PEND_BIT = 2;

  // Instruction codes
  localparam logic [7:0] IC_PRD_LO = 8'h00;
  localparam logic [7:0] IC_PRD_HI = 8'h63;
  localparam logic [7:0] IC_PWR_LO = 8'h80;
  localparam logic [7:0] IC_PWR_HI = 8'hE3;
  localparam logic [7:0] IC_FAULT_CLR = 8'hF4;
  localparam logic [7:0] IC_PARAM_CLR = 8'hFC;
  localparam logic [7:0] IC_DRV_RESET = 8'hFD;
  localparam logic [7:0] IC_SECOND_RD = 8'h6C;
  localparam logic [7:0] IC_SECOND_WR = 8'hEC;
  localparam logic [7:0] IC_SPMON_RD = 8'h73;
  localparam logic [7:0] IC_SPMON_WR = 8'hF3;
  localparam logic [7:0] IC_LINK_EXT_WR = 8'hFF;

  // Data keys and special values
  localparam logic [15:0] KEY_9696 = 16'h9696;
  localparam logic [15:0] KEY_5A5A = 16'h5A5A;
  localparam logic [15:0] KEY_9966 = 16'h9966;
  localparam logic [15:0] KEY_55AA = 16'h55AA;
  localparam logic [15:0] RAW_8888 = 16'hFFF0;
  localparam logic [15:0] RAW_9999 = 16'hFFFF;
  localparam logic [15:0] VAL_8888 = 16'h22B8;
  localparam logic [15:0] VAL_9999 = 16'h270F;
  localparam logic [15:0] SAT16 = 16'hFFFF;
  localparam logic [7:0] SECOND_SEL_MAX = 8'h02;
  localparam logic [7:0] LINK_EXT_ONE = 8'h01;
  localparam logic [7:0] LINK_EXT_NINE = 8'h09;

  // Reset values
  localparam logic [7:0] RST_SECOND_SEL = 8'h00;
  localparam logic [7:0] RST_SPMON_SEL = 8'h01;
  localparam logic [7:0] RST_LINK_EXT = 8'h00;

  // Monitor codes
  localparam logic [7:0] MC_FREQ0 = 8'h00;
  localparam logic [7:0] MC_FREQ1 = 8'h01;
  localparam logic [7:0] MC_CURRENT = 8'h02;
  localparam logic [7:0] MC_VOLTAGE = 8'h03;
  localparam logic [7:0] MC_SET_FREQ = 8'h05;

  typedef struct packed {
    logic [31:0] out_freq;
    logic [31:0] out_current;
    logic [31:0] out_voltage;
    logic [31:0] set_freq;
  } dich_mon_src_t;

  typedef struct packed {
    logic fault_clear;
    logic param_clear;
    logic all_clear;
    logic clear_comm;
    logic drive_reset;
    logic param_wr;
    logic param_rd;
    logic [7:0] param_idx;
    logic [15:0] param_val;
  } dich_cmd_out_t;

  typedef struct packed {
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
    logic ram_only;
    logic [7:0] link_ext;
    logic [7:0] second_sel;
    logic [7:0] spmon_sel;
    logic last_ok;
    logic last_err;
    logic rd_pend;
    logic [15:0] rdata;
    logic [15:0] msel_first;
    logic [NUM_MSEL_MORE-1:0][15:0] msel_more;
    logic [NUM_MRES-1:0][15:0] mres;
    dich_cmd_out_t cmd;
  } dich_state_t;

  function automatic logic [15:0] sat16(input logic [31:0] v);
    return (v > {16'h0000, SAT16}) ? SAT16 : v[15:0];
  endfunction

endpackage

// [rtl/dich_top.sv]
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module dich_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dich_pkg::dich_mon_src_t mon_src,
  input wire logic [31:0] param_rdata,
  output dich_pkg::dich_cmd_out_t cmd_out,
  output logic param_ram_only,
  output logic [7:0] second_sel,
  output logic [7:0] link_ext
);

  dich_pkg::dich_state_t st_ff;
  dich_pkg::dich_state_t nxt_st;
  logic [dich_pkg::NUM_MRES-1:0][15:0] mon_val;
  logic [dich_pkg::NUM_MRES-1:0][7:0] mon_code;
  logic [dich_pkg::NUM_MRES-1:0] mon_upper;
  logic addr_valid;
  logic [7:0] cmd_code;
  logic [15:0] cmd_data;
  logic ext_ok;

  assign addr_valid = hsel & htrans[1] & hready;
  assign cmd_code = hwdata[dich_pkg::CMD_CODE_LSB +: 8];
  assign cmd_data = hwdata[dich_pkg::CMD_DATA_LSB +: 16];
  assign ext_ok = (st_ff.link_ext == dich_pkg::LINK_EXT_ONE) ||
                  (st_ff.link_ext == dich_pkg::LINK_EXT_NINE);

  // Lower byte of the first word feeds the first result, upper the second
  always_comb begin
    mon_code[0] = st_ff.msel_first[7:0];
    mon_upper[0] = 1'b0;
    mon_code[1] = st_ff.msel_first[15:8];
    mon_upper[1] = 1'b1;
    for (int i = 0; i < dich_pkg::NUM_MSEL_MORE; i++) begin
      mon_code[i+2] = st_ff.msel_more[i][7:0];
      mon_upper[i+2] = 1'b0;
    end
  end

  for (genvar g = 0; g < dich_pkg::NUM_MRES; g++) begin : g_mon
    dich_mon_map u_map (
      .code(mon_code[g]),
      .upper(mon_upper[g]),
      .src(mon_src),
      .value(mon_val[g])
    );
  end

  function automatic logic [7:0] msel_more_ofs(input int i);
    return 8'(dich_pkg::OFS_MSEL_THIRD + 8'(4 * i));
  endfunction

  function automatic logic [7:0] mres_ofs(input int i);
    return 8'(dich_pkg::OFS_MRES_FIRST + 8'(4 * i));
  endfunction

  function automatic logic [31:0] rd_mux(input dich_pkg::dich_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == dich_pkg::OFS_CTRL) begin
      r[dich_pkg::CTRL_RAM_ONLY_BIT] = s.ram_only;
      r[dich_pkg::CTRL_LINK_EXT_LSB +: 8] = s.link_ext;
    end else if (a == dich_pkg::OFS_STAT) begin
      r[dich_pkg::STAT_OK_BIT] = s.last_ok;
      r[dich_pkg::STAT_ERR_BIT] = s.last_err;
      r[dich_pkg::STAT_RD_PEND_BIT] = s.rd_pend;
    end else if (a == dich_pkg::OFS_RDATA) begin
      r[15:0] = s.rdata;
    end else if (a == dich_pkg::OFS_MSEL_FIRST) begin
      r[15:0] = s.msel_first;
    end else begin
      for (int i = 0; i < dich_pkg::NUM_MSEL_MORE; i++) begin
        if (a == msel_more_ofs(i)) begin
          r[15:0] = s.msel_more[i];
        end
      end
      for (int i = 0; i < dich_pkg::NUM_MRES; i++) begin
        if (a == mres_ofs(i)) begin
          r[15:0] = s.mres[i];
        end
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] pwr_value(input logic [15:0] d);
    if (d == dich_pkg::RAW_8888) begin
      return dich_pkg::VAL_8888;
    end else if (d == dich_pkg::RAW_9999) begin
      return dich_pkg::VAL_9999;
    end
    return d;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    // Command strobes are single-cycle pulses
    nxt_st.cmd.fault_clear = 1'b0;
    nxt_st.cmd.param_clear = 1'b0;
    nxt_st.cmd.all_clear = 1'b0;
    nxt_st.cmd.drive_reset = 1'b0;
    nxt_st.cmd.param_wr = 1'b0;
    nxt_st.cmd.param_rd = 1'b0;
    nxt_st.mres = mon_val;

    // Parameter read data arrives the cycle after the read strobe
    // A read strobe in the capture cycle re-arms, so a close second read is not lost
    if (st_ff.rd_pend) begin
      nxt_st.rdata = dich_pkg::sat16(param_rdata);
      nxt_st.rd_pend = st_ff.cmd.param_rd;
    end else if (st_ff.cmd.param_rd) begin
      nxt_st.rd_pend = 1'b1;
    end

    // Data phase of the previous address phase
    if (st_ff.dph_valid && st_ff.dph_write) begin
      if (st_ff.dph_addr == dich_pkg::OFS_CTRL) begin
        nxt_st.ram_only = hwdata[dich_pkg::CTRL_RAM_ONLY_BIT];
      end else if (st_ff.dph_addr == dich_pkg::OFS_MSEL_FIRST) begin
        nxt_st.msel_first = hwdata[15:0];
      end else if (st_ff.dph_addr == dich_pkg::OFS_CMD) begin
        nxt_st.last_ok = 1'b1;
        nxt_st.last_err = 1'b0;
        if (cmd_code >= dich_pkg::IC_PWR_LO && cmd_code <= dich_pkg::IC_PWR_HI) begin
          nxt_st.cmd.param_wr = 1'b1;
          nxt_st.cmd.param_idx = cmd_code;
          nxt_st.cmd.param_val = pwr_value(cmd_data);
        end else if (cmd_code <= dich_pkg::IC_PRD_HI) begin
          nxt_st.cmd.param_rd = 1'b1;
          nxt_st.cmd.param_idx = cmd_code;
        end else if (cmd_code == dich_pkg::IC_FAULT_CLR) begin
          if (cmd_data == dich_pkg::KEY_9696) begin
            nxt_st.cmd.fault_clear = 1'b1;
          end else begin
            nxt_st.last_ok = 1'b0;
            nxt_st.last_err = 1'b1;
          end
        end else if (cmd_code == dich_pkg::IC_PARAM_CLR) begin
          if (cmd_data == dich_pkg::KEY_9696 || cmd_data == dich_pkg::KEY_5A5A) begin
            nxt_st.cmd.param_clear = 1'b1;
            nxt_st.cmd.clear_comm = (cmd_data == dich_pkg::KEY_9696);
          end else if (cmd_data == dich_pkg::KEY_9966 || cmd_data == dich_pkg::KEY_55AA) begin
            nxt_st.cmd.all_clear = 1'b1;
            nxt_st.cmd.clear_comm = (cmd_data == dich_pkg::KEY_9966);
          end else begin
            nxt_st.last_ok = 1'b0;
            nxt_st.last_err = 1'b1;
          end
          if (nxt_st.cmd.param_clear || nxt_st.cmd.all_clear) begin
            nxt_st.second_sel = dich_pkg::RST_SECOND_SEL;
            nxt_st.spmon_sel = dich_pkg::RST_SPMON_SEL;
            nxt_st.link_ext = dich_pkg::RST_LINK_EXT;
          end
        end else if (cmd_code == dich_pkg::IC_DRV_RESET) begin
          if (cmd_data == dich_pkg::KEY_9696) begin
            nxt_st.cmd.drive_reset = 1'b1;
          end else begin
            nxt_st.last_ok = 1'b0;
            nxt_st.last_err = 1'b1;
          end
        end else if (cmd_code == dich_pkg::IC_SECOND_WR) begin
          if (ext_ok && cmd_data <= {8'h00, dich_pkg::SECOND_SEL_MAX}) begin
            nxt_st.second_sel = cmd_data[7:0];
          end else begin
            nxt_st.last_ok = 1'b0;
            nxt_st.last_err = 1'b1;
          end
        end else if (cmd_code == dich_pkg::IC_SECOND_RD) begin
          if (ext_ok) begin
            nxt_st.rdata = {8'h00, st_ff.second_sel};
          end else begin
            nxt_st.last_ok = 1'b0;
            nxt_st.last_err = 1'b1;
          end
        end else if (cmd_code == dich_pkg::IC_SPMON_WR) begin
          nxt_st.spmon_sel = cmd_data[7:0];
        end else if (cmd_code == dich_pkg::IC_SPMON_RD) begin
          nxt_st.rdata = {8'h00, st_ff.spmon_sel};
        end else if (cmd_code == dich_pkg::IC_LINK_EXT_WR) begin
          nxt_st.link_ext = cmd_data[7:0];
        end else begin
          nxt_st.last_ok = 1'b0;
          nxt_st.last_err = 1'b1;
        end
      end else begin
        for (int i = 0; i < dich_pkg::NUM_MSEL_MORE; i++) begin
          if (st_ff.dph_addr == msel_more_ofs(i)) begin
            nxt_st.msel_more[i] = hwdata[15:0];
          end
        end
      end
    end

    // Address phase; read data is registered so the slave never waits
    nxt_st.dph_valid = addr_valid;
    nxt_st.dph_write = hwrite;
    nxt_st.dph_addr = haddr[7:0];
    // Read from the updated copy so a pipelined read sees a write in its data phase
    if (addr_valid && !hwrite) begin
      nxt_st.hrdata = (haddr[31:8] == 24'h000000) ? rd_mux(nxt_st, haddr[7:0]) : 32'h0000_0000;
    end
    if (addr_valid && haddr[31:8] != 24'h000000) begin
      nxt_st.dph_valid = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.second_sel <= dich_pkg::RST_SECOND_SEL;
      st_ff.spmon_sel <= dich_pkg::RST_SPMON_SEL;
      st_ff.link_ext <= dich_pkg::RST_LINK_EXT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    hrdata = st_ff.hrdata;
    hreadyout = 1'b1;
    hresp = 1'b0;
    cmd_out = st_ff.cmd;
    param_ram_only = st_ff.ram_only;
    second_sel = st_ff.second_sel;
    link_ext = st_ff.link_ext;
  end

endmodule
`default_nettype wire

// [verif/dich_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module dich_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire dich_pkg::dich_cmd_out_t cmd_out,
  input wire logic [7:0] second_sel,
  input wire logic [7:0] link_ext
);
  logic cw_ff;
  logic [15:0] key;
  logic [7:0] code;
  assign key = hwdata[31:16];
  assign code = hwdata[7:0];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // High during the data phase of a command write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cw_ff <= 1'b0;
    end else if (hready) begin
      cw_ff <= hsel && htrans[1] && hwrite && haddr == {24'h0, dich_pkg::OFS_CMD};
    end
  end
  fault_clear_a: assert property (cw_ff && code == 8'hF4 && key == 16'h9696 |=> cmd_out.fault_clear)
    else $error("fault clear pulse missing");
  // Key top bit tells the comm choice for all four clear keys
  param_clear_a: assert property (cw_ff && code == 8'hFC && key inside {16'h9696, 16'h5A5A}
    |=> cmd_out.param_clear && cmd_out.clear_comm == $past(hwdata[31])) else $error("param clear wrong");
  all_clear_a: assert property (cw_ff && code == 8'hFC && key inside {16'h9966, 16'h55AA}
    |=> cmd_out.all_clear && cmd_out.clear_comm == $past(hwdata[31])) else $error("all clear wrong");
  drive_reset_a: assert property (cw_ff && code == 8'hFD && key == 16'h9696 |=> cmd_out.drive_reset)
    else $error("drive reset pulse missing");
  no_action_a: assert property (cw_ff && code inside {8'hF4, 8'hFD} && key != 16'h9696
    |=> !cmd_out.fault_clear && !cmd_out.drive_reset) else $error("action on bad key");
  clear_dflt_a: assert property (cmd_out.param_clear || cmd_out.all_clear
    |-> ##[0:1] second_sel == 8'h00 && link_ext == 8'h00) else $error("settings kept after clear");
  sel_range_a: assert property (second_sel <= 8'h02) else $error("second select out of range");
  sel_gate_a: assert property ($changed(second_sel) && second_sel != 8'h00
    |-> $past(link_ext) inside {8'h01, 8'h09}) else $error("second select changed without extension");
  special_val_a: assert property (cw_ff && code inside {[8'h80:8'hE3]} && key == 16'hFFF0
    |=> cmd_out.param_wr && cmd_out.param_val == 16'h22B8) else $error("special value not mapped");
endmodule
`default_nettype wire

// [verif/dich_store_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dich_store_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire dich_pkg::dich_cmd_out_t cmd_out,
  output logic [31:0] param_rdata
);
  logic [15:0] mem [128];
  // Code 10 holds a 32-bit value; the bus toggles when not answering so a late sample shows
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      param_rdata <= 32'h0;
      foreach (mem[i]) mem[i] <= 16'h0;
    end else begin
      if (cmd_out.param_wr) begin
        mem[cmd_out.param_idx[6:0]] <= cmd_out.param_val;
      end
      if (cmd_out.param_rd) begin
        param_rdata <= (cmd_out.param_idx == 8'h10) ? 32'h0001_2345 : {16'h0, mem[cmd_out.param_idx[6:0]]};
      end else begin
        param_rdata <= ~param_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/dich_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t: got %h exp %h", $time, a, b); end end
module dich_top_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, param_rdata, rd;
  logic hreadyout, hresp, param_ram_only, last_comm;
  logic [7:0] second_sel, link_ext;
  dich_pkg::dich_mon_src_t mon_src = '0;
  dich_pkg::dich_cmd_out_t cmd_out;
  int mismatches = 0;
  int checks_done = 0;
  int n_fault = 0;
  int n_rst = 0;
  int n_pclr = 0;
  int n_aclr = 0;
  logic [7:0] ext [2] = '{8'h01, 8'h09};
  logic [15:0] key [4] = '{16'h9696, 16'h5A5A, 16'h9966, 16'h55AA};
  logic [31:0] mexp [4] = '{32'h0, 32'h1111, 32'h2222, 32'h3333};
  initial begin
    forever #2 hclk = ~hclk;
  end
  dich_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .mon_src, .param_rdata, .cmd_out, .param_ram_only, .second_sel, .link_ext);
  dich_store_model i_store (.hclk, .hresetn, .cmd_out, .param_rdata);
  // Pulses are counted so checks do not hinge on the exact cycle
  always @(posedge hclk) begin
    n_fault += int'(cmd_out.fault_clear === 1'b1);
    n_rst += int'(cmd_out.drive_reset === 1'b1);
    n_pclr += int'(cmd_out.param_clear === 1'b1);
    n_aclr += int'(cmd_out.all_clear === 1'b1);
    if (cmd_out.param_clear || cmd_out.all_clear) last_comm = cmd_out.clear_comm;
  end
  task automatic results;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        results;
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  // Two cycles cover the pulse and the one-cycle store answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge hclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(hresp, 1'b0)
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] k);
    wr(dich_pkg::OFS_CMD, {k, 8'h00, c});
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h40, 32'h0);
    wr(dich_pkg::OFS_CTRL, 32'h1);
    `CHK(param_ram_only, 1'b1)
    rdc(dich_pkg::OFS_CTRL, 32'h1);
    cmd(8'h80, 16'hFFF0);
    `CHK(cmd_out.param_val, 16'h22B8)
    cmd(8'h81, 16'hFFFF);
    cmd(8'h01, 16'h0);
    rdc(dich_pkg::OFS_RDATA, 32'h270F);
    cmd(8'h10, 16'h0);
    rdc(dich_pkg::OFS_RDATA, 32'hFFFF);
    cmd(8'hEC, 16'h1);
    `CHK(second_sel, 8'h00)
    rdc(dich_pkg::OFS_STAT, 32'h2);
    cmd(8'h73, 16'h0);
    cmd(8'h6C, 16'h0);
    rdc(dich_pkg::OFS_STAT, 32'h2);
    rdc(dich_pkg::OFS_RDATA, 32'h1);
    foreach (ext[i]) begin
      cmd(8'hFF, {8'h00, ext[i]});
      for (int v = 0; v < 3; v++) begin
        cmd(8'hEC, 16'(v));
        `CHK(second_sel, 8'(v))
      end
      cmd(8'hEC, 16'h3);
      `CHK(second_sel, 8'h02)
      cmd(8'h6C, 16'h0);
      rdc(dich_pkg::OFS_RDATA, 32'h2);
    end
    rdc(dich_pkg::OFS_STAT, 32'h1);
    cmd(8'hF3, 16'hAB05);
    cmd(8'h73, 16'h0);
    rdc(dich_pkg::OFS_RDATA, 32'h5);
    mon_src <= {32'h1111, 32'h2222, 32'h3333, 32'h0002_0000};
    wr(dich_pkg::OFS_MSEL_FIRST, 32'h0302);
    rdc(8'h24, 32'h2222);
    rdc(8'h28, 32'h3333);
    wr(dich_pkg::OFS_MSEL_FIRST, 32'h0500);
    rdc(8'h24, 32'h0);
    rdc(8'h28, 32'hFFFF);
    wr(dich_pkg::OFS_MSEL_FIRST, 32'h0001);
    rdc(8'h24, 32'h1111);
    rdc(8'h28, 32'h1111);
    for (int i = 0; i < 4; i++) begin
      wr(8'(dich_pkg::OFS_MSEL_THIRD + 4 * i), 32'hFF00 | i);
      rdc(8'(8'h2C + 4 * i), mexp[i]);
    end
    foreach (key[i]) begin
      cmd(8'hFF, 16'h9);
      cmd(8'hEC, 16'h1);
      cmd(8'hFC, key[i]);
      `CHK({second_sel, link_ext}, 16'h0)
      `CHK(last_comm, key[i][15])
    end
    `CHK({n_pclr, n_aclr}, {32'd2, 32'd2})
    cmd(8'h73, 16'h0);
    rdc(dich_pkg::OFS_RDATA, 32'h1);
    cmd(8'hF4, 16'h1234);
    cmd(8'hFD, 16'h9697);
    cmd(8'hFC, 16'h1234);
    `CHK({n_fault, n_rst, n_pclr + n_aclr}, {32'd0, 32'd0, 32'd4})
    cmd(8'hF4, 16'h9696);
    `CHK(n_fault, 1)
    cmd(8'hFD, 16'h9696);
    `CHK(n_rst, 1)
    // Mid-run reset must bring back the default settings
    cmd(8'hFF, 16'h9);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK({second_sel, link_ext, param_ram_only}, 17'h0)
    cmd(8'hEC, 16'h1);
    `CHK(second_sel, 8'h00)
    cmd(8'h73, 16'h0);
    rdc(dich_pkg::OFS_RDATA, 32'h1);
    results;
  end
endmodule
bind dich_top dich_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .cmd_out,
  .second_sel, .link_ext);
`default_nettype wire
